/* design/cpm_pkg.sv */
/*
  Constants of the clock and power controller.
  Assumes one 50 MHz core clock.
*/
package cpm_pkg;

  localparam int unsigned CORE_CLK_MHZ = 50;

  localparam int unsigned OSC_SETTLE_US = 1000;
  localparam int unsigned PLL_LOCK_US = 300;
  localparam int unsigned PWR_SETTLE_US = 6000;

  localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_US * CORE_CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CORE_CLK_MHZ;
  localparam int unsigned PWR_SETTLE_CYC = PWR_SETTLE_US * CORE_CLK_MHZ;

  localparam int unsigned WAIT_W = 20;
  localparam int unsigned ULOCK_W = 16;

  localparam logic [1:0] HCLK_DIV1 = 2'h0;
  localparam logic [1:0] HCLK_DIV2 = 2'h1;
  localparam logic [1:0] HCLK_DIV4 = 2'h2;
  localparam logic [1:0] HCLK_RSVD = 2'h3;
  localparam logic [1:0] HCLK_SEL_RST = 2'h0;
  localparam logic PCLK_SEL_RST = 1'h0;

  localparam logic [7:0] SLEEP_KEY = 8'hA3;

  localparam int unsigned RATIO_W = 6;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;

  localparam int unsigned EXT_INT_W = 10;
  localparam int unsigned BATT_WAKE_W = 2;

  typedef enum logic [3:0] {
    ST_NORMAL,
    ST_LOCK,
    ST_IDLE,
    ST_STOP_SR,
    ST_STOP,
    ST_STOP_OSC,
    ST_STOP_LOCK,
    ST_SLEEP_SR,
    ST_SLEEP,
    ST_SLEEP_PWR
  } cpm_state_t;

endpackage

/* design/cpm_tick_div.sv */
/*
  Divider: one registered tick per ratio source ticks.
  Assumes ratio >= 1 and a same-clock src_tick.
*/
`timescale 1ns/100ps
`default_nettype none

module cpm_tick_div #(
  parameter int unsigned W = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic src_tick,
  input wire logic [W-1:0] ratio,
  input wire logic run,
  output logic tick_q
);

  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] ratio_q, ratio_d;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    ratio_d = ratio_q;
    tick_d = 1'b0;
    if (!run) begin
      // gate acts at once; ratio reloads while stopped
      cnt_d = '0;
      ratio_d = ratio;
    end else if (src_tick) begin
      // ratio swaps at period end: no runt
      if (cnt_q >= W'(ratio_q - 1'b1)) begin
        cnt_d = '0;
        ratio_d = ratio;
        tick_d = 1'b1;
      end else begin
        cnt_d = W'(cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      ratio_q <= W'(1);
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ratio_q <= ratio_d;
      tick_q <= tick_d;
    end
  end

endmodule

`default_nettype wire

/* design/cpm_clock_power_ctrl.sv */
/*
  Clock divider and power mode controller; clocks are one-cycle
  enable ticks on core_clk (main PLL or reference clock).
  usb_pll_tick marks USB PLL output edges.
  Assumes sr_ack comes back on core_clk.
  Wake pins and warm reset are asynchronous.
  Cold reset is rst_b.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - PLL rewrite inserts lock, clocks held
// - bus clock cpu/1,/2,/4; periph bus/1 or /2
// - video: 0 is bus clock, else /2n
// - camera: 0 is USB PLL/2, else USB PLL/2(n+1)
// - divided clocks follow source at once
// - usb clock is USB PLL over two
// - USB PLL off in stop and sleep
// - usb clock low in lock, off powered down
// - block gates follow enables at once
// - idle stops only the cpu clock
// - idle/stop start on rising edge
// - stop halts oscillator, PLLs, all clocks
// - stop wakes on interrupts and resets
// - no clock during settle and lock
// - stop waits refresh ack before shutdown
// - stop exit: settle, lock, switch
// - refresh released at first access
// - sleep removes clocks and core power
// - sleep: refresh, shutdown, regulator off
// - sleep exit: power, settle, sync reset
module cpm_clock_power_ctrl
  import cpm_pkg::*;
#(
  parameter int unsigned NUM_BLOCKS = 8,
  parameter int unsigned OSC_WAIT_CYCLES = cpm_pkg::OSC_SETTLE_CYC,
  parameter int unsigned LOCK_CYCLES = cpm_pkg::PLL_LOCK_CYC,
  parameter int unsigned PWR_WAIT_CYCLES = cpm_pkg::PWR_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pll_cfg_wr,
  input wire logic usb_pll_cfg_wr,
  input wire logic [1:0] hclk_ratio_sel,
  input wire logic pclk_ratio_sel,
  input wire logic [3:0] video_accel_div,
  input wire logic [3:0] camera_clk_div,
  input wire logic [NUM_BLOCKS-1:0] block_clk_en,
  input wire logic usb_clk_on,
  input wire logic infrared_clk_on,
  input wire logic camera_clk_on,
  input wire logic usb_pll_power_down,
  input wire logic usb_pll_tick,
  input wire logic idle_mode_bit,
  input wire logic stop_mode_bit,
  input wire logic sleep_key_wr,
  input wire logic [7:0] sleep_entry_key,
  input wire logic batt_sleep_en,
  input wire logic batt_fault_n,
  input wire logic [cpm_pkg::EXT_INT_W-1:0] ext_int,
  input wire logic rtc_alarm,
  input wire logic pen_down_int,
  input wire logic modem_int,
  input wire logic warm_reset_n,
  input wire logic sr_ack,
  input wire logic sdram_access_pend,
  output logic cpu_clk_tick,
  output logic system_bus_clk_tick,
  output logic peripheral_bus_clk_tick,
  output logic video_accel_clk_tick,
  output logic camera_clk_tick,
  output logic usb_clk_tick,
  output logic infrared_clk_tick,
  output logic [NUM_BLOCKS-1:0] block_clk_tick,
  output logic sr_req,
  output logic osc_en,
  output logic main_pll_en,
  output logic usb_pll_en,
  output logic pll_src_sel,
  output logic core_power_off_n,
  output logic sys_reset_n,
  output logic [1:0] power_mode
);

  localparam int unsigned PIN_W = EXT_INT_W + 5;

  // two-stage sync; logic reads stage two only
  logic [PIN_W-1:0] pin_meta_q, pin_sync_q;
  logic [PIN_W-1:0] pin_raw;
  logic batt_prev_q;

  assign pin_raw = {batt_fault_n, warm_reset_n, modem_int, pen_down_int,
                    rtc_alarm, ext_int};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= {2'h3, {(PIN_W-2){1'b0}}};
      pin_sync_q <= {2'h3, {(PIN_W-2){1'b0}}};
      batt_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      batt_prev_q <= pin_sync_q[PIN_W-1];
    end
  end

  logic [EXT_INT_W-1:0] ext_int_s;
  logic rtc_s, pen_s, modem_s, warm_n_s, batt_n_s;
  logic wake_stop, wake_sleep_sw, wake_sleep_batt, batt_fall;

  assign ext_int_s = pin_sync_q[EXT_INT_W-1:0];
  assign rtc_s = pin_sync_q[EXT_INT_W];
  assign pen_s = pin_sync_q[EXT_INT_W+1];
  assign modem_s = pin_sync_q[EXT_INT_W+2];
  assign warm_n_s = pin_sync_q[EXT_INT_W+3];
  assign batt_n_s = pin_sync_q[EXT_INT_W+4];
  assign batt_fall = batt_prev_q && !batt_n_s;

  assign wake_stop = (|ext_int_s) || rtc_s || pen_s || modem_s
                     || !warm_n_s;
  assign wake_sleep_sw = (|ext_int_s) || rtc_s || !warm_n_s;
  // battery sleep wakes on two lowest lines
  assign wake_sleep_batt = (|ext_int_s[BATT_WAKE_W-1:0]) || !warm_n_s;

  // mode bit edge detection
  logic idle_prev_q, stop_prev_q;
  logic idle_rise, stop_rise, sleep_req;

  assign idle_rise = idle_mode_bit && !idle_prev_q;
  assign stop_rise = stop_mode_bit && !stop_prev_q;
  assign sleep_req = (sleep_key_wr && sleep_entry_key == SLEEP_KEY)
                     || (batt_sleep_en && batt_fall);

  // power mode state machine
  cpm_state_t state_q, state_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic pll_cfgd_q, pll_cfgd_d;
  logic batt_sleep_q, batt_sleep_d;
  logic sr_req_d;
  logic wait_done;

  assign wait_done = (wait_q == '0);

  always_comb begin
    state_d = state_q;
    wait_d = wait_done ? wait_q : WAIT_W'(wait_q - 1'b1);
    pll_cfgd_d = pll_cfgd_q;
    batt_sleep_d = batt_sleep_q;
    unique case (state_q)
      ST_NORMAL: begin
        if (sleep_req) begin
          state_d = ST_SLEEP_SR;
          batt_sleep_d = batt_sleep_en && batt_fall;
        end else if (stop_rise) begin
          state_d = ST_STOP_SR;
        end else if (idle_rise) begin
          state_d = ST_IDLE;
        end else if (pll_cfg_wr) begin
          state_d = ST_LOCK;
          wait_d = WAIT_W'(LOCK_CYCLES - 1);
        end
      end
      ST_LOCK: begin
        if (wait_done) begin
          state_d = ST_NORMAL;
          pll_cfgd_d = 1'b1;
        end
      end
      ST_IDLE: begin
        if (wake_stop) begin
          state_d = ST_NORMAL;
        end
      end
      ST_STOP_SR: begin
        if (sr_ack) begin
          state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_stop) begin
          state_d = ST_STOP_OSC;
          wait_d = WAIT_W'(OSC_WAIT_CYCLES - 1);
        end
      end
      ST_STOP_OSC: begin
        if (wait_done) begin
          state_d = ST_STOP_LOCK;
          wait_d = WAIT_W'(LOCK_CYCLES - 1);
        end
      end
      ST_STOP_LOCK: begin
        if (wait_done) begin
          state_d = ST_NORMAL;
        end
      end
      ST_SLEEP_SR: begin
        if (sr_ack) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (batt_sleep_q ? wake_sleep_batt : wake_sleep_sw) begin
          state_d = ST_SLEEP_PWR;
          wait_d = WAIT_W'(PWR_WAIT_CYCLES - 1);
        end
      end
      ST_SLEEP_PWR: begin
        if (wait_done) begin
          // as after power-on: reference clock until PLL set
          state_d = ST_NORMAL;
          pll_cfgd_d = 1'b0;
          batt_sleep_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
    // held until the first access after wake
    sr_req_d = sr_req;
    if (state_d == ST_STOP_SR || state_d == ST_SLEEP_SR) begin
      sr_req_d = 1'b1;
    end else if (state_d == ST_NORMAL && sdram_access_pend) begin
      sr_req_d = 1'b0;
    end
  end

  // decoded from next state, so outputs are flops
  logic osc_en_d, main_pll_en_d, pll_src_sel_d, power_off_n_d;
  logic sys_reset_n_d, bus_run_d, cpu_run_d, pll_off_mode_d;
  logic [1:0] mode_d;

  always_comb begin
    pll_off_mode_d = (state_d == ST_STOP) || (state_d == ST_STOP_OSC)
                     || (state_d == ST_SLEEP) || (state_d == ST_SLEEP_PWR);
    osc_en_d = !(state_d == ST_STOP || state_d == ST_SLEEP);
    main_pll_en_d = !pll_off_mode_d;
    power_off_n_d = (state_d != ST_SLEEP);
    // reset lifts on an edge once supply settles
    sys_reset_n_d = !(state_d == ST_SLEEP || state_d == ST_SLEEP_PWR);
    pll_src_sel_d = pll_cfgd_d
                    && (state_d == ST_NORMAL || state_d == ST_IDLE);
    bus_run_d = (state_d == ST_NORMAL) || (state_d == ST_IDLE);
    cpu_run_d = (state_d == ST_NORMAL);
    unique case (state_d)
      ST_IDLE: mode_d = MODE_IDLE;
      ST_STOP_SR, ST_STOP, ST_STOP_OSC, ST_STOP_LOCK: mode_d = MODE_STOP;
      ST_SLEEP_SR, ST_SLEEP, ST_SLEEP_PWR: mode_d = MODE_SLEEP;
      default: mode_d = MODE_NORMAL;
    endcase
  end

  logic bus_run_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_NORMAL;
      wait_q <= '0;
      pll_cfgd_q <= 1'b0;
      batt_sleep_q <= 1'b0;
      idle_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
      sr_req <= 1'b0;
      osc_en <= 1'b1;
      main_pll_en <= 1'b1;
      pll_src_sel <= 1'b0;
      core_power_off_n <= 1'b1;
      sys_reset_n <= 1'b1;
      bus_run_q <= 1'b1;
      cpu_clk_tick <= 1'b0;
      power_mode <= MODE_NORMAL;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      pll_cfgd_q <= pll_cfgd_d;
      batt_sleep_q <= batt_sleep_d;
      idle_prev_q <= idle_mode_bit;
      stop_prev_q <= stop_mode_bit;
      sr_req <= sr_req_d;
      osc_en <= osc_en_d;
      main_pll_en <= main_pll_en_d;
      pll_src_sel <= pll_src_sel_d;
      core_power_off_n <= power_off_n_d;
      sys_reset_n <= sys_reset_n_d;
      bus_run_q <= bus_run_d;
      cpu_clk_tick <= cpu_run_d;
      power_mode <= mode_d;
    end
  end

  // reserved ratio code is never taken
  logic [1:0] hclk_sel_q, hclk_sel_d;
  logic [RATIO_W-1:0] hclk_ratio, pclk_ratio, video_ratio, cam_ratio;

  always_comb begin
    hclk_sel_d = hclk_sel_q;
    if (hclk_ratio_sel != HCLK_RSVD) begin
      hclk_sel_d = hclk_ratio_sel;
    end
    unique case (hclk_sel_q)
      HCLK_DIV2: hclk_ratio = RATIO_W'(2);
      HCLK_DIV4: hclk_ratio = RATIO_W'(4);
      default: hclk_ratio = RATIO_W'(1);
    endcase
    pclk_ratio = pclk_ratio_sel ? RATIO_W'(2) : RATIO_W'(1);
    video_ratio = (video_accel_div == 4'h0) ? RATIO_W'(1)
                  : RATIO_W'({video_accel_div, 1'b0});
    cam_ratio = {1'b0, camera_clk_div, 1'b0} + RATIO_W'(2);
  end

  // USB PLL power and lock tracking
  logic usb_on_d;
  logic [ULOCK_W-1:0] ulock_q, ulock_d;
  logic usb_ok_q, usb_ok_d;

  always_comb begin
    usb_on_d = !usb_pll_power_down && !pll_off_mode_d;
    ulock_d = ulock_q;
    if (!usb_on_d) begin
      ulock_d = '0;
    end else if (usb_pll_cfg_wr || !usb_pll_en) begin
      ulock_d = ULOCK_W'(LOCK_CYCLES);
    end else if (ulock_q != '0) begin
      ulock_d = ULOCK_W'(ulock_q - 1'b1);
    end
    // low through lock, absent while powered down
    usb_ok_d = usb_on_d && (ulock_d == '0);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hclk_sel_q <= HCLK_SEL_RST;
      usb_pll_en <= 1'b1;
      ulock_q <= '0;
      usb_ok_q <= 1'b1;
    end else begin
      hclk_sel_q <= hclk_sel_d;
      usb_pll_en <= usb_on_d;
      ulock_q <= ulock_d;
      usb_ok_q <= usb_ok_d;
    end
  end

  logic usb_src;
  assign usb_src = usb_pll_tick && usb_ok_q;

  // ratio changes only at each stage's own boundary
  cpm_tick_div #(.W(RATIO_W)) u_hclk_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(bus_run_q),
    .ratio(hclk_ratio),
    .run(bus_run_q),
    .tick_q(system_bus_clk_tick)
  );

  cpm_tick_div #(.W(RATIO_W)) u_pclk_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(system_bus_clk_tick),
    .ratio(pclk_ratio),
    .run(bus_run_q),
    .tick_q(peripheral_bus_clk_tick)
  );

  // fed by bus ticks, so ratio changes carry
  cpm_tick_div #(.W(RATIO_W)) u_video_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(system_bus_clk_tick),
    .ratio(video_ratio),
    .run(bus_run_q),
    .tick_q(video_accel_clk_tick)
  );

  cpm_tick_div #(.W(RATIO_W)) u_cam_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(usb_src),
    .ratio(cam_ratio),
    .run(camera_clk_on && usb_ok_q),
    .tick_q(camera_clk_tick)
  );

  cpm_tick_div #(.W(RATIO_W)) u_usb_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(usb_src),
    .ratio(RATIO_W'(2)),
    .run(usb_clk_on && usb_ok_q),
    .tick_q(usb_clk_tick)
  );

  cpm_tick_div #(.W(RATIO_W)) u_ir_div (
    .clk(core_clk),
    .rst_b(rst_b),
    .src_tick(usb_src),
    .ratio(RATIO_W'(1)),
    .run(infrared_clk_on && usb_ok_q),
    .tick_q(infrared_clk_tick)
  );

  // block gates, one cycle behind bus tick
  logic [NUM_BLOCKS-1:0] blk_d;

  always_comb begin
    blk_d = block_clk_en & {NUM_BLOCKS{system_bus_clk_tick}};
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_clk_tick <= '0;
    end else begin
      block_clk_tick <= blk_d;
    end
  end

endmodule

`default_nettype wire

/* test/cpm_sdram_model.sv */
/*
  Self-refresh handshake partner of the SDRAM controller.
  Assumes sr_req is a level; slow lengthens the answer.
*/
`timescale 1ns/100ps
`default_nettype none

module cpm_sdram_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sr_req,
  input wire logic slow,
  output logic sr_ack
);
  logic [2:0] wait_q;

  // ack after the refresh command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 3'h0;
      sr_ack <= 1'b0;
    end else if (!sr_req) begin
      wait_q <= 3'h0;
      sr_ack <= 1'b0;
    end else if (wait_q == (slow ? 3'h5 : 3'h1)) begin
      sr_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule

`default_nettype wire

/* test/cpm_clock_power_ctrl_sva.sv */
/*
  Port checker, bound to the controller top.
  Assumes sim waits of 8, 12, 16 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module cpm_clock_power_ctrl_sva
  import cpm_pkg::*;
#(
  parameter int unsigned NUM_BLOCKS = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] hclk_ratio_sel,
  input wire logic pclk_ratio_sel,
  input wire logic [NUM_BLOCKS-1:0] block_clk_en,
  input wire logic sr_ack,
  input wire logic cpu_clk_tick,
  input wire logic system_bus_clk_tick,
  input wire logic peripheral_bus_clk_tick,
  input wire logic usb_clk_tick,
  input wire logic [NUM_BLOCKS-1:0] block_clk_tick,
  input wire logic sr_req,
  input wire logic osc_en,
  input wire logic main_pll_en,
  input wire logic core_power_off_n,
  input wire logic sys_reset_n,
  input wire logic [1:0] power_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_cpu_gated: assert property (
    power_mode != MODE_NORMAL |-> !cpu_clk_tick)
    else $error("cpu tick not normal");
  chk_stop_quiet: assert property (
    power_mode == MODE_STOP && !osc_en && !$past(osc_en)
      |-> !system_bus_clk_tick && !usb_clk_tick && block_clk_tick == '0)
    else $error("tick while stopped");
  chk_ack_first: assert property (
    $fell(osc_en) |-> sr_req && $past(sr_ack))
    else $error("osc off before ack");
  chk_regulator_last: assert property (
    $fell(core_power_off_n) |-> !osc_en && !main_pll_en && sr_req)
    else $error("regulator off early");
  chk_osc_settle: assert property (
    $rose(osc_en) && power_mode == MODE_STOP
      |-> !main_pll_en [*7] ##[1:4] main_pll_en)
    else $error("no osc wait");
  chk_lock_wait: assert property (
    $rose(main_pll_en) && power_mode == MODE_STOP
      |-> power_mode == MODE_STOP [*8] ##[1:8] power_mode == MODE_NORMAL)
    else $error("no lock wait");
  chk_power_settle: assert property (
    $rose(core_power_off_n) |-> !sys_reset_n [*8] ##[1:12] sys_reset_n)
    else $error("reset before settle");
  chk_sleep_reset: assert property (
    !core_power_off_n |-> !sys_reset_n)
    else $error("reset high, power off");
  chk_periph_half: assert property (
    peripheral_bus_clk_tick && pclk_ratio_sel && $past(pclk_ratio_sel)
      |=> !peripheral_bus_clk_tick)
    else $error("periph not halved");
  chk_bus_div4: assert property (
    system_bus_clk_tick && hclk_ratio_sel == HCLK_DIV4
      && $past(hclk_ratio_sel) == HCLK_DIV4
      && $past(hclk_ratio_sel, 2) == HCLK_DIV4 |=> !system_bus_clk_tick [*3])
    else $error("bus above quarter rate");
  chk_usb_half: assert property (
    usb_clk_tick |=> !usb_clk_tick)
    else $error("usb tick not halved");
  chk_block_gate: assert property (
    (block_clk_tick & ~$past(block_clk_en)) == '0)
    else $error("gated block ticked");

  cov_idle: cover property (power_mode == MODE_IDLE);
  cov_stop: cover property ($fell(osc_en) && power_mode == MODE_STOP);
  cov_sleep: cover property ($fell(core_power_off_n));
  cov_div4: cover property (system_bus_clk_tick
    && hclk_ratio_sel == HCLK_DIV4);
endmodule

bind cpm_clock_power_ctrl cpm_clock_power_ctrl_sva #(
  .NUM_BLOCKS(NUM_BLOCKS)
) u_sva (.core_clk, .rst_b, .hclk_ratio_sel, .pclk_ratio_sel,
  .block_clk_en, .sr_ack, .cpu_clk_tick, .system_bus_clk_tick,
  .peripheral_bus_clk_tick, .usb_clk_tick, .block_clk_tick, .sr_req,
  .osc_en, .main_pll_en, .core_power_off_n, .sys_reset_n, .power_mode);

`default_nettype wire

/* test/cpm_clock_power_ctrl_tb_top.sv */
/*
  Self-checking bench for the controller.
  Assumes waits of 8, 12, 16 cycles and a USB PLL edge each cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module cpm_clock_power_ctrl_tb_top;
  import cpm_pkg::*;
  localparam int unsigned NB = 4;
  localparam int LOCK_W = 12;
  typedef struct packed {
    logic [1:0] h; logic p; logic [3:0] v; logic [3:0] c;
    logic [7:0] bus; logic [7:0] per; logic [7:0] vid; logic [7:0] cam;
  } cpm_row_t;
  // last row: reserved code keeps quarter rate
  cpm_row_t rows [5] = '{
    '{2'h0, 1'h0, 4'h0, 4'h0, 8'h01, 8'h01, 8'h01, 8'h02},
    '{2'h0, 1'h1, 4'h1, 4'h1, 8'h01, 8'h02, 8'h02, 8'h04},
    '{2'h1, 1'h1, 4'h2, 4'h3, 8'h02, 8'h04, 8'h08, 8'h08},
    '{2'h2, 1'h0, 4'h3, 4'hF, 8'h04, 8'h04, 8'h18, 8'h20},
    '{2'h3, 1'h1, 4'h5, 4'h0, 8'h04, 8'h08, 8'h28, 8'h02}};
  logic core_clk, rst_b, pll_cfg_wr, usb_pll_cfg_wr, pclk_ratio_sel, slow;
  logic usb_clk_on, infrared_clk_on, camera_clk_on, usb_pll_power_down;
  logic usb_pll_tick, idle_mode_bit, stop_mode_bit, sleep_key_wr;
  logic batt_sleep_en, batt_fault_n, rtc_alarm, pen_down_int, modem_int;
  logic warm_reset_n, sr_ack, sdram_access_pend, sr_req, osc_en;
  logic main_pll_en, usb_pll_en, pll_src_sel, core_power_off_n, sys_reset_n;
  logic cpu_clk_tick, system_bus_clk_tick, peripheral_bus_clk_tick;
  logic video_accel_clk_tick, camera_clk_tick, usb_clk_tick;
  logic infrared_clk_tick;
  logic [1:0] hclk_ratio_sel, power_mode;
  logic [3:0] video_accel_div, camera_clk_div;
  logic [7:0] sleep_entry_key;
  logic [NB-1:0] block_clk_en, block_clk_tick;
  logic [EXT_INT_W-1:0] ext_int;
  wire [7:0] tk;
  int num_errors, num_checks, cycles, n, p;

  assign tk = {block_clk_tick[0], infrared_clk_tick, usb_clk_tick,
    camera_clk_tick, video_accel_clk_tick, peripheral_bus_clk_tick,
    system_bus_clk_tick, cpu_clk_tick};

  cpm_clock_power_ctrl #(.NUM_BLOCKS(NB), .OSC_WAIT_CYCLES(8),
    .LOCK_CYCLES(LOCK_W), .PWR_WAIT_CYCLES(16)) dut (.core_clk, .rst_b,
    .pll_cfg_wr, .usb_pll_cfg_wr, .hclk_ratio_sel, .pclk_ratio_sel,
    .video_accel_div, .camera_clk_div, .block_clk_en, .usb_clk_on,
    .infrared_clk_on, .camera_clk_on, .usb_pll_power_down, .usb_pll_tick,
    .idle_mode_bit, .stop_mode_bit, .sleep_key_wr, .sleep_entry_key,
    .batt_sleep_en, .batt_fault_n, .ext_int, .rtc_alarm, .pen_down_int,
    .modem_int, .warm_reset_n, .sr_ack, .sdram_access_pend, .cpu_clk_tick,
    .system_bus_clk_tick, .peripheral_bus_clk_tick, .video_accel_clk_tick,
    .camera_clk_tick, .usb_clk_tick, .infrared_clk_tick, .block_clk_tick,
    .sr_req, .osc_en, .main_pll_en, .usb_pll_en, .pll_src_sel,
    .core_power_off_n, .sys_reset_n, .power_mode);

  cpm_sdram_model sdram (.core_clk, .rst_b, .sr_req, .slow, .sr_ack);

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_vec(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_int(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // gap between two ticks
  task automatic period(input int idx, output int q);
    q = 0;
    while (tk[idx] !== 1'b1 && q < 200) begin
      cyc(1);
      q++;
    end
    cyc(1);
    q = 1;
    while (tk[idx] !== 1'b1 && q < 200) begin
      cyc(1);
      q++;
    end
  endtask

  task automatic count(input int idx, input int k, output int c);
    c = 0;
    repeat (k) begin
      cyc(1);
      c += int'(tk[idx] === 1'b1);
    end
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    while (power_mode !== m && k < 100) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic wake(input int s, input logic v);
    case (s)
      0: ext_int[3] = v;
      1: rtc_alarm = v;
      2: pen_down_int = v;
      3: modem_int = v;
      default: warm_reset_n = !v;
    endcase
  endtask

  task automatic first_access();
    sdram_access_pend = 1'b1;
    cyc(2);
    check_vec("sr_req released", 8'h00, sr_req);
    sdram_access_pend = 1'b0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    {rst_b, pll_cfg_wr, usb_pll_cfg_wr, pclk_ratio_sel, slow} = '0;
    {usb_pll_power_down, idle_mode_bit, stop_mode_bit, sleep_key_wr} = '0;
    {batt_sleep_en, rtc_alarm, pen_down_int, modem_int} = '0;
    {usb_clk_on, infrared_clk_on, camera_clk_on, usb_pll_tick} = '1;
    {batt_fault_n, warm_reset_n, sdram_access_pend} = 3'h6;
    {hclk_ratio_sel, video_accel_div, camera_clk_div, ext_int} = '0;
    {sleep_entry_key, block_clk_en} = {8'h00, {NB{1'b1}}};
    cyc(2);
    check_vec("rst osc_en", 8'h01, osc_en);
    check_vec("rst sr_req", 8'h00, sr_req);
    check_vec("rst power", 8'h01, core_power_off_n);
    check_vec("rst sys_reset", 8'h01, sys_reset_n);
    check_vec("rst mode", MODE_NORMAL, power_mode);
    check_vec("rst cpu tick", 8'h00, cpu_clk_tick);
    cyc(8);
    rst_b = 1'b1;
    cyc(5);
    check_vec("usb after rst", 8'h01, tk[5]);
    foreach (rows[i]) begin
      {hclk_ratio_sel, pclk_ratio_sel} = {rows[i].h, rows[i].p};
      {video_accel_div, camera_clk_div} = {rows[i].v, rows[i].c};
      cyc(80);
      period(1, p);
      check_int("bus period", rows[i].bus, p);
      period(2, p);
      check_int("periph period", rows[i].per, p);
      period(3, p);
      check_int("video period", rows[i].vid, p);
      period(4, p);
      check_int("camera period", rows[i].cam, p);
      period(5, p);
      check_int("usb period", 2, p);
      period(6, p);
      check_int("infrared period", 1, p);
    end
    {hclk_ratio_sel, pclk_ratio_sel} = '0;
    cyc(10);
    pll_cfg_wr = 1'b1;
    cyc(1);
    pll_cfg_wr = 1'b0;
    cyc(1);
    count(1, LOCK_W - 3, n);
    check_int("bus lock", 0, n);
    cyc(6);
    check_vec("cpu after lock", 8'h01, cpu_clk_tick);
    check_vec("pll source", 8'h01, pll_src_sel);
    block_clk_en[0] = 1'b0;
    count(7, 20, n);
    check_int("gated block", 0, n);
    block_clk_en[0] = 1'b1;
    count(7, 20, n);
    check_int("ungated block", 1, int'(n >= 19));
    idle_mode_bit = 1'b1;
    cyc(3);
    check_vec("idle mode", MODE_IDLE, power_mode);
    count(1, 10, n);
    check_int("idle bus", 10, n);
    rtc_alarm = 1'b1;
    cyc(3);
    rtc_alarm = 1'b0;
    wait_mode(MODE_NORMAL);
    cyc(20);
    check_vec("idle level", MODE_NORMAL, power_mode);
    idle_mode_bit = 1'b0;
    for (int s = 0; s < 5; s++) begin
      slow = s[0];
      stop_mode_bit = 1'b1;
      cyc(3);
      check_vec("stop sr_req", 8'h01, sr_req);
      check_vec("osc before ack", 8'h01, osc_en);
      cyc(10);
      check_vec("stop osc", 8'h00, osc_en | main_pll_en | usb_pll_en);
      count(5, 10, n);
      check_int("usb stop", 0, n);
      wake(s, 1'b1);
      cyc(3);
      wake(s, 1'b0);
      wait_mode(MODE_NORMAL);
      check_vec("stop woken", MODE_NORMAL, power_mode);
      check_vec("stop src", 8'h01, pll_src_sel);
      check_vec("sr_req held", 8'h01, sr_req);
      stop_mode_bit = 1'b0;
      first_access();
    end
    for (int k = 0; k < 2; k++) begin
      sleep_entry_key = k == 0 ? 8'h5C : SLEEP_KEY;
      sleep_key_wr = 1'b1;
      cyc(1);
      sleep_key_wr = 1'b0;
      cyc(12);
    end
    check_vec("sleep mode", MODE_SLEEP, power_mode);
    check_vec("core power off", 8'h00, core_power_off_n);
    ext_int[0] = 1'b1;
    cyc(4);
    ext_int[0] = 1'b0;
    check_vec("power back on", 8'h01, core_power_off_n);
    wait_mode(MODE_NORMAL);
    check_vec("sys reset off", 8'h01, sys_reset_n);
    check_vec("sleep src", 8'h00, pll_src_sel);
    first_access();
    batt_sleep_en = 1'b1;
    batt_fault_n = 1'b0;
    cyc(15);
    batt_fault_n = 1'b1;
    rtc_alarm = 1'b1;
    cyc(12);
    rtc_alarm = 1'b0;
    check_vec("battery sleep", MODE_SLEEP, power_mode);
    ext_int[1] = 1'b1;
    cyc(4);
    ext_int[1] = 1'b0;
    wait_mode(MODE_NORMAL);
    check_vec("battery wake", MODE_NORMAL, power_mode);
    first_access();
    usb_pll_power_down = 1'b1;
    cyc(3);
    count(5, 20, n);
    check_int("usb down", 0, n);
    usb_pll_power_down = 1'b0;
    cyc(LOCK_W + 6);
    usb_pll_cfg_wr = 1'b1;
    cyc(1);
    usb_pll_cfg_wr = 1'b0;
    cyc(1);
    count(5, LOCK_W - 3, n);
    check_int("usb lock", 0, n);
    cyc(6);
    usb_clk_on = 1'b0;
    cyc(3);
    count(5, 20, n);
    check_int("usb off", 0, n);
    give_verdict();
  end
endmodule

`default_nettype wire
